//--- src/scc_pkg.sv
// shared constants and types of the static clock controller
package scc_pkg;
    // divider periods counted in half cycles of the master frequency
    localparam logic [10:0] FAST_PERIOD  = 11'h006;  // divide by 3
    localparam logic [10:0] SLOW_PERIOD  = 11'h600;  // divide by 768
    localparam logic [10:0] FAST_HIGH    = 11'h002;  // 33% of fast period
    localparam logic [10:0] SLOW_HIGH    = 11'h200;  // 33% of slow period
    localparam logic [3:0]  PER_PERIOD   = 4'hc;     // divide by 6
    localparam logic [3:0]  PER_HIGH     = 4'h6;     // 50% of peripheral
    // speed select filter, in full master cycles
    localparam logic [7:0]  SLOW_FILTER  = 8'hc3;    // 195 cycles low
    localparam logic [7:0]  FAST_FILTER  = 8'h06;    // 6 cycles high
    // oscillator warm-up terminal count, in crystal cycles
    localparam int          WARM_CYCLES  = 8192;
    // reset values
    localparam logic [10:0] PHASE_RST    = 11'h000;
    localparam logic [3:0]  PPHASE_RST   = 4'h0;
    localparam logic [7:0]  FILT_RST     = 8'h00;
    localparam logic [13:0] WARM_RST     = 14'h0000;

    typedef enum logic [3:0] {
        ST_RUN  = 4'b0001,
        ST_HALT = 4'b0010,
        ST_WARM = 4'b0100,
        ST_SYNC = 4'b1000
    } scc_state_t;

    typedef struct packed {
        logic haltLine;   // status line 2, low active stop
        logic line1;
        logic line0;
    } scc_status_t;

    typedef struct packed {
        logic processorClock;
        logic halfDutyClock;
        logic peripheralClock;
        logic oscillatorOutput;
        logic crystalOutput;
    } scc_clocks_t;
endpackage

//--- src/scc_edge.sv
// edge detector for a level sampled on the system clock
`timescale 1ns/1ps
module scc_edge #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic clk,    // system clock
    input  wire logic srst,   // synchronous reset, active high
    input  wire logic level,  // sampled level
    output logic      rise,   // one-cycle pulse on low to high
    output logic      fall    // one-cycle pulse on high to low
);
    typedef struct packed {
        logic prev;
    } scc_edge_state_t;

    scc_edge_state_t state_ff;
    scc_edge_state_t nxt_state;

    always_comb begin
        nxt_state      = state_ff;
        nxt_state.prev = level;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            // a level already high across reset is not taken as an edge
            state_ff.prev <= RESET_LEVEL | level;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rise = level & ~state_ff.prev;
    assign fall = ~level & state_ff.prev;
endmodule

//--- src/scc_clock_controller.sv
// static clock controller: dividers, halt decode, restart sequencing
`timescale 1ns/1ps
import scc_pkg::*;

// Functional notes
// - source select low takes crystal input, high takes external input.
// - start rising edge restarts all three clocks after restart sequence.
// - crystal restart waits for oscillator activity and 8K cycle count.
// - external mode resumes clocks within three external cycles of start.
// - restart keeps the speed mode in force when clocks stopped.
// - speed select: fast divides master by 3, slow by 768.
// - halt status on status lines is decoded to stop clocks.
// - processor clock 33% duty, half-duty clock 50%, both synchronized.
// - stop on LHH at processor clock rise following HHH there.
// - peripheral clock is master divided by 6, 50% duty, in both speed modes.
// - slow needs 195 low source cycles, fast needs 6 high.
// - crystal-mode stop halts oscillator; external-mode stop only outputs.
module scc_clock_controller #(
    parameter int WARM_COUNT = scc_pkg::WARM_CYCLES // crystal warm-up cycles
) (
    input  wire logic                clk,            // system clock
    input  wire logic                srst,           // sync reset, high
    input  wire logic                crystalInput,   // crystal input level
    input  wire logic                externalFrequencyInput, // ext source
    input  wire logic                sourceSelect,   // 0 crystal, 1 external
    input  wire logic                speedSelect,    // 1 fast, 0 slow
    input  wire logic                start,          // restart request
    input  wire scc_pkg::scc_status_t statusLines,   // processor status
    output scc_pkg::scc_clocks_t     clocks,         // generated clocks
    output logic                     clocksStopped,  // outputs are halted
    output logic                     slowMode        // slow mode in force
);
    import scc_pkg::*;

    localparam logic [13:0] WARM_LAST = 14'(WARM_COUNT - 1);

    typedef struct packed {
        scc_state_t  st;
        logic [10:0] phase;     // processor divider, half cycles
        logic [3:0]  pphase;    // peripheral divider, half cycles
        logic        slow;      // speed mode in force
        logic        slowReq;   // filtered speed select
        logic        filtLvl;   // level the filter is timing
        logic [7:0]  filtCnt;
        logic        prevIdle;  // HHH seen at last processor clock rise
        logic        oscRun;    // crystal oscillator running
        logic [13:0] warmCnt;
        scc_clocks_t out;
    } scc_ctrl_t;

    scc_ctrl_t state_ff;
    scc_ctrl_t nxt_state;

    logic xRise;
    logic xFall;
    logic eRise;
    logic eFall;
    logic startRise;

    scc_edge #(.RESET_LEVEL(1'b0)) u_xtalEdge (
        .clk   (clk),
        .srst  (srst),
        .level (crystalInput),
        .rise  (xRise),
        .fall  (xFall)
    );

    scc_edge #(.RESET_LEVEL(1'b0)) u_extEdge (
        .clk   (clk),
        .srst  (srst),
        .level (externalFrequencyInput),
        .rise  (eRise),
        .fall  (eFall)
    );

    scc_edge #(.RESET_LEVEL(1'b1)) u_startEdge (
        .clk   (clk),
        .srst  (srst),
        .level (start),
        .rise  (startRise),
        .fall  ()
    );

    // master half-cycle ticks from the selected source
    logic        masterRise;
    logic        halfTick;
    logic [10:0] period;
    logic [10:0] highLen;
    logic        wrap;
    logic        stopSeen;
    logic        idleSeen;

    always_comb begin
        // the oscillator only yields edges while it runs
        if (sourceSelect) begin
            masterRise = eRise;
            halfTick   = eRise | eFall;
        end else begin
            masterRise = xRise & state_ff.oscRun;
            halfTick   = (xRise | xFall) & state_ff.oscRun;
        end
        period   = state_ff.slow ? SLOW_PERIOD : FAST_PERIOD;
        highLen  = state_ff.slow ? SLOW_HIGH : FAST_HIGH;
        wrap     = halfTick && (state_ff.phase == period - 11'h001);
        // status lines as seen at the processor clock rise
        stopSeen = ~statusLines.haltLine & statusLines.line1
                   & statusLines.line0;
        idleSeen = statusLines.haltLine & statusLines.line1
                   & statusLines.line0;
    end

    always_comb begin
        nxt_state = state_ff;

        // speed select filter runs on full master cycles
        if (masterRise) begin
            if (speedSelect != state_ff.filtLvl) begin
                nxt_state.filtLvl = speedSelect;
                nxt_state.filtCnt = 8'h01;
            end else if (state_ff.filtCnt != 8'hff) begin
                nxt_state.filtCnt = state_ff.filtCnt + 8'h01;
            end
            if (!speedSelect && nxt_state.filtCnt >= SLOW_FILTER) begin
                nxt_state.slowReq = 1'b1;
            end
            if (speedSelect && nxt_state.filtCnt >= FAST_FILTER) begin
                nxt_state.slowReq = 1'b0;
            end
        end

        // oscillator pin drive is the inverted input while it runs
        nxt_state.out.crystalOutput = state_ff.oscRun & ~crystalInput;

        unique case (state_ff.st)
            ST_RUN: begin
                nxt_state.out.oscillatorOutput =
                    sourceSelect ? externalFrequencyInput : crystalInput;
                if (halfTick) begin
                    nxt_state.phase = wrap ? PHASE_RST
                                           : state_ff.phase + 11'h001;
                    nxt_state.pphase =
                        (state_ff.pphase == PER_PERIOD - 4'h1)
                        ? PPHASE_RST : state_ff.pphase + 4'h1;
                end
                if (wrap) begin
                    // speed changes only at a period boundary, so
                    // no short pulse reaches the processor
                    nxt_state.slow = state_ff.slowReq;
                    nxt_state.prevIdle = idleSeen;
                    if (stopSeen && state_ff.prevIdle) begin
                        nxt_state.st = ST_HALT;
                        // processor clock freezes high, half-duty clock low, at the rise
                        nxt_state.phase = PHASE_RST;
                        if (!sourceSelect) begin
                            nxt_state.oscRun = 1'b0;
                            nxt_state.out.oscillatorOutput = 1'b1;
                            nxt_state.out.crystalOutput = 1'b0;
                        end
                    end
                end
                nxt_state.out.processorClock =
                    nxt_state.phase < highLen;
                nxt_state.out.halfDutyClock =
                    (nxt_state.phase >= highLen) &&
                    (nxt_state.phase < highLen + (period >> 1));
                nxt_state.out.peripheralClock = nxt_state.pphase < PER_HIGH;
            end
            ST_HALT: begin
                // divided clocks hold, oscillator output follows the external input in external mode; speed mode is kept for the restart
                if (sourceSelect) begin
                    nxt_state.out.oscillatorOutput = externalFrequencyInput;
                end
                if (startRise) begin
                    nxt_state.prevIdle = 1'b0;
                    if (sourceSelect || state_ff.oscRun) begin
                        nxt_state.st = ST_SYNC;
                    end else begin
                        nxt_state.st = ST_WARM;
                        nxt_state.oscRun = 1'b1;
                        nxt_state.warmCnt = WARM_RST;
                    end
                end
            end
            ST_WARM: begin
                // a crystal edge shows the input crossed its threshold
                if (xRise) begin
                    if (state_ff.warmCnt == WARM_LAST) begin
                        nxt_state.st = ST_SYNC;
                    end else begin
                        nxt_state.warmCnt = state_ff.warmCnt + 14'h0001;
                    end
                end
            end
            ST_SYNC: begin
                // resume on the next master rise, well within 3 cycles
                if (masterRise) begin
                    nxt_state.st = ST_RUN;
                    nxt_state.phase = PHASE_RST;
                    // phase 0 levels, so the first high is a full one
                    nxt_state.out.processorClock = 1'b1;
                    nxt_state.out.halfDutyClock = 1'b0;
                    nxt_state.out.peripheralClock =
                        state_ff.pphase < PER_HIGH;
                end
            end
            default: begin
                nxt_state.st = ST_HALT;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff.st       <= ST_SYNC;
            state_ff.phase    <= PHASE_RST;
            state_ff.pphase   <= PPHASE_RST;
            state_ff.slow     <= 1'b0;
            state_ff.slowReq  <= 1'b0;
            state_ff.filtLvl  <= 1'b1;
            state_ff.filtCnt  <= FILT_RST;
            state_ff.prevIdle <= 1'b0;
            state_ff.oscRun   <= 1'b1;
            state_ff.warmCnt  <= WARM_RST;
            state_ff.out      <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign clocks        = state_ff.out;
    assign clocksStopped = state_ff.st != ST_RUN;
    assign slowMode      = state_ff.slow;

    // checks
    property p_stop_decode;
        @(posedge clk) disable iff (srst)
        (state_ff.st == ST_RUN && wrap && stopSeen && state_ff.prevIdle)
            |=> (state_ff.st == ST_HALT && clocks.processorClock);
    endproperty
    a_stop_decode: assert property (p_stop_decode)
        else $error("halt pattern did not stop clocks high");

    property p_no_stop_without_idle;
        @(posedge clk) disable iff (srst)
        (state_ff.st == ST_RUN && !state_ff.prevIdle)
            |=> (state_ff.st != ST_HALT);
    endproperty
    a_no_stop_without_idle: assert property (p_no_stop_without_idle)
        else $error("clocks stopped without passive pattern first");

    property p_halt_holds;
        @(posedge clk) disable iff (srst)
        (state_ff.st == ST_HALT && $past(state_ff.st) == ST_HALT)
            |-> $stable(clocks.peripheralClock)
                && $stable(clocks.halfDutyClock);
    endproperty
    a_halt_holds: assert property (p_halt_holds)
        else $error("clock output moved while halted");

    property p_crystal_stop;
        @(posedge clk) disable iff (srst)
        (state_ff.st == ST_HALT && !sourceSelect && !state_ff.oscRun)
            |-> (clocks.oscillatorOutput && !clocks.crystalOutput);
    endproperty
    a_crystal_stop: assert property (p_crystal_stop)
        else $error("oscillator not stopped high in crystal halt");

    property p_ext_keeps_osc;
        @(posedge clk) disable iff (srst)
        (state_ff.st == ST_RUN && wrap && stopSeen && state_ff.prevIdle
         && sourceSelect) |=> state_ff.oscRun;
    endproperty
    a_ext_keeps_osc: assert property (p_ext_keeps_osc)
        else $error("oscillator stopped in external mode");

    property p_warm_count;
        @(posedge clk) disable iff (srst)
        (state_ff.st == ST_WARM ##1 state_ff.st == ST_SYNC)
            |-> ($past(state_ff.warmCnt) == WARM_LAST);
    endproperty
    a_warm_count: assert property (p_warm_count)
        else $error("warm-up left before terminal count");

    property p_ext_resume;
        @(posedge clk) disable iff (srst)
        (state_ff.st == ST_SYNC && masterRise) |=> (state_ff.st == ST_RUN);
    endproperty
    a_ext_resume: assert property (p_ext_resume)
        else $error("clocks did not resume on master edge");

    property p_speed_kept;
        @(posedge clk) disable iff (srst)
        (state_ff.st != ST_RUN) |=> $stable(state_ff.slow);
    endproperty
    a_speed_kept: assert property (p_speed_kept)
        else $error("speed mode changed while stopped");

    property p_duty;
        @(posedge clk) disable iff (srst)
        (state_ff.st == ST_RUN && !state_ff.slow)
            |-> (clocks.processorClock == (state_ff.phase < FAST_HIGH))
                && !(clocks.processorClock && clocks.halfDutyClock);
    endproperty
    a_duty: assert property (p_duty)
        else $error("processor or half-duty clock phase wrong");

    property p_periph;
        @(posedge clk) disable iff (srst)
        (state_ff.st == ST_RUN)
            |-> (clocks.peripheralClock == (state_ff.pphase < PER_HIGH));
    endproperty
    a_periph: assert property (p_periph)
        else $error("peripheral clock phase wrong");

    property p_slow_filter;
        @(posedge clk) disable iff (srst)
        $rose(state_ff.slowReq) |-> state_ff.filtCnt >= SLOW_FILTER;
    endproperty
    a_slow_filter: assert property (p_slow_filter)
        else $error("slow mode taken before filter time");

    property p_speed_at_boundary;
        @(posedge clk) disable iff (srst)
        $changed(state_ff.slow) |-> (state_ff.phase == PHASE_RST);
    endproperty
    a_speed_at_boundary: assert property (p_speed_at_boundary)
        else $error("speed changed away from period boundary");

    property p_source;
        @(posedge clk) disable iff (srst)
        (sourceSelect && state_ff.st == ST_RUN)
            |=> clocks.oscillatorOutput == $past(externalFrequencyInput);
    endproperty
    a_source: assert property (p_source)
        else $error("external source not routed");
endmodule

//--- test/scc_cpu_model.sv
// processor model: drives halt status on processor clock rises
`timescale 1ns/1ps
module scc_cpu_model
    import scc_pkg::*;
(
    input  wire logic            clk,         // system clock
    input  wire logic            procClock,   // processor clock
    input  wire logic            haltReq,     // bench asks for a halt
    output scc_pkg::scc_status_t statusLines  // status to controller
);
    logic procClockLast;

    initial begin
        statusLines = 3'h7;
        procClockLast = 1'h0;
    end

    // halt pattern only after a rise, so the previous rise saw idle
    always @(posedge clk) begin
        procClockLast <= procClock;
        if (!haltReq) begin
            statusLines <= 3'h7;
        end else if (procClock && !procClockLast) begin
            statusLines <= 3'h3;
        end
    end
endmodule

//--- test/testbench.sv
// self-checking bench for the static clock controller
`timescale 1ns/1ps
module testbench;
    import scc_pkg::*;
    localparam int WARM = 4;
    logic        clk;
    logic        srst;
    logic        crystalInput;
    logic        extIn;
    logic        sourceSelect;
    logic        speedSelect;
    logic        start;
    logic        haltReq;
    logic        clocksStopped;
    logic        slowMode;
    logic [4:0]  clkVec;
    scc_status_t statusLines;
    scc_clocks_t clocks;
    int          num_errors;
    int          checks;

    assign clkVec = clocks;

    scc_clock_controller #(.WARM_COUNT(WARM)) u_scc_clock_controller (
        .clk(clk), .srst(srst), .crystalInput(crystalInput),
        .externalFrequencyInput(extIn), .sourceSelect(sourceSelect),
        .speedSelect(speedSelect), .start(start),
        .statusLines(statusLines), .clocks(clocks),
        .clocksStopped(clocksStopped), .slowMode(slowMode));

    scc_cpu_model u_scc_cpu_model (.clk(clk),
        .procClock(clocks.processorClock), .haltReq(haltReq),
        .statusLines(statusLines));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // the sources run at different rates so a wrong mux shows as a period
    initial forever begin
        repeat (3) @(posedge clk);
        extIn <= ~extIn;
    end
    initial forever begin
        repeat (4) @(posedge clk);
        crystalInput <= ~crystalInput;
    end

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic checkBit(string name, logic exp, logic got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s exp %b got %b", name, exp, got);
        end
    endtask

    task automatic checkRange(string name, int lo, int hi, int got);
        checks++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("unexpected %s exp %0d..%0d got %0d", name, lo, hi, got);
        end
    endtask

    task automatic timeOut(string name);
        num_errors++;
        $display("unexpected %s exp done got timeout", name);
        finish_test();
    endtask

    // w selects slowMode, else clocksStopped
    task automatic waitSig(logic w, logic v, int lim, output int n);
        n = 0;
        while ((w ? slowMode : clocksStopped) !== v && n < lim) begin
            step();
            n++;
        end
        if ((w ? slowMode : clocksStopped) !== v) timeOut("wait");
    endtask

    // s walks: wait low, wait high, count high, count low
    task automatic checkClk(int idx, string name, int per, int hi);
        int n, h, p, s;
        n = 0;
        h = 0;
        p = 0;
        s = 0;
        while (s < 4 && n < 12000) begin
            if (clkVec[idx] === s[0]) begin
                s++;
            end else begin
                step();
                n++;
                h += (s == 2);
                p += (s >= 2);
            end
        end
        if (s < 4) timeOut(name);
        checkRange(name, per, per, p);
        checkRange(name, hi, hi, h);
    endtask

    task automatic doReset(logic src);
        @(posedge clk);
        srst <= 1'h1;
        sourceSelect <= src;
        repeat (6) @(posedge clk);
        #1;
        checkBit("clocksStopped", 1'h1, clocksStopped);
        checkBit("slowMode", 1'h0, slowMode);
        @(posedge clk);
        srst <= 1'h0;
    endtask

    task automatic halt(int lim, output int tg);
        int n;
        logic p, o;
        @(posedge clk);
        haltReq <= 1'h1;
        waitSig(1'h0, 1'h1, lim, n);
        step();
        checkBit("procStop", 1'h1, clocks.processorClock);
        p = clocks.peripheralClock;
        o = clocks.oscillatorOutput;
        tg = 0;
        repeat (40) begin
            step();
            tg += (clocks.oscillatorOutput !== o);
            o = clocks.oscillatorOutput;
        end
        checkBit("perFrozen", p, clocks.peripheralClock);
        @(posedge clk);
        haltReq <= 1'h0;
    endtask

    task automatic restart(int lo, int hi);
        int n;
        @(posedge clk);
        start <= 1'h1;
        waitSig(1'h0, 1'h0, hi + 5, n);
        checkRange("restart", lo, hi, n);
        @(posedge clk);
        start <= 1'h0;
    endtask

    task automatic fastExt();
        int tg;
        checkClk(4, "proc", 18, 6);
        checkBit("halfAtRise", 1'h0, clocks.halfDutyClock);
        repeat (6) step();
        checkBit("halfAtFall", 1'h1, clocks.halfDutyClock);
        checkClk(3, "half", 18, 9);
        checkClk(2, "per", 36, 18);
        halt(60, tg);
        checkRange("oscRuns", 1, 40, tg);
        restart(1, 21);
        checkClk(4, "procAgain", 18, 6);
    endtask

    task automatic slowExt();
        int n, tg;
        @(posedge clk);
        speedSelect <= 1'h0;
        repeat (180 * 6) step();
        checkBit("slowEarly", 1'h0, slowMode);
        waitSig(1'h1, 1'h1, 300, n);
        checkClk(4, "procSlow", 4608, 1536);
        checkClk(3, "halfSlow", 4608, 2304);
        checkClk(2, "perSlow", 36, 18);
        halt(9300, tg);
        restart(1, 21);
        checkBit("slowKept", 1'h1, slowMode);
        checkClk(4, "procKept", 4608, 1536);
        @(posedge clk);
        speedSelect <= 1'h1;
        waitSig(1'h1, 1'h0, 4700, n);
        checkRange("fastDelay", 30, 4700, n);
    endtask

    task automatic crystal();
        int tg;
        doReset(1'h0);
        checkClk(4, "procXtal", 24, 8);
        halt(80, tg);
        checkRange("oscStill", 0, 0, tg);
        checkBit("oscHigh", 1'h1, clocks.oscillatorOutput);
        checkBit("xtalOutLow", 1'h0, clocks.crystalOutput);
        restart((WARM - 1) * 8, (WARM + 2) * 8);
        checkClk(2, "perXtal", 48, 24);
    endtask

    initial begin
        srst = 1'h1;
        crystalInput = 1'h0;
        extIn = 1'h0;
        sourceSelect = 1'h1;
        speedSelect = 1'h1;
        start = 1'h0;
        haltReq = 1'h0;
        num_errors = 0;
        checks = 0;
        doReset(1'h1);
        fastExt();
        slowExt();
        crystal();
        finish_test();
    end
endmodule
